/* File: design/cgrf_regfile.sv */
// Purpose: general register file with aliased views, pointers and status
// Assumes: execution logic drives requests synchronous to sys_clk
// Notes: reads are registered, one cycle after the request
//
// Function
// - sixteen 32-bit registers, 64 bytes; every view aliases this store
// - first 16 bytes addressable as byte registers, high then low per word
// - first 16 words are word registers; word 0 never index or address
// - even longwords 0..30 usable; longword 0 never index or address
// - quadword registers at every fourth longword index 0..28
// - compact mode: word 15 stack pointer, word 14 frame pointer
// - linear/segmented: longword 14 stack pointer, longword 12 frame pointer
// - 32-bit PC and 16-bit flag word saved on trap or interrupt
// - datapath does byte, word and longword logic and arithmetic
// - addresses 16 bits in compact mode, 32 bits otherwise
// - flag word selects modes, holds masks, carries result flags
// - extended and linear bits pick compact, segmented, linear or reserved
`timescale 1ns/1ps
module cgrf_regfile
    import cgrf_pkg::*;
(
    // clock and control
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // read port
    input wire logic rd_req,
    input wire cgrf_sel_t rd_sel,
    // write / execute port
    input wire logic wr_req,
    input wire cgrf_sel_t wr_sel,
    input wire logic [63:0] wr_data,
    input wire logic alu_en,
    input wire cgrf_op_t alu_op,
    input wire cgrf_sel_t alu_src,
    // address register fetch
    input wire logic addr_req,
    input wire logic [4:0] addr_num,
    // program status
    input wire logic pc_load,
    input wire logic [31:0] pc_value,
    input wire logic fcw_load,
    input wire logic [15:0] fcw_value,
    input wire logic trap_take,
    input wire logic [31:0] trap_pc,
    input wire logic [15:0] trap_fcw,
    // outputs
    output logic [63:0] rd_data,
    output logic rd_valid,
    output logic [31:0] addr_data,
    output logic addr_valid,
    output logic addr_err,
    output logic [31:0] stack_ptr,
    output logic [31:0] frame_ptr,
    output cgrf_amode_t addr_mode,
    output cgrf_status_t status,
    output cgrf_status_t saved_status,
    output logic saved_valid
);
    typedef struct packed {
        logic [CGRF_NUM_LONGS-1:0][31:0] file;
        cgrf_status_t st;
        cgrf_status_t sv;
        logic sv_ok;
        logic [63:0] rd;
        logic rd_ok;
        logic [31:0] ad;
        logic ad_ok;
        logic ad_err;
        logic [31:0] sp;
        logic [31:0] fp;
        cgrf_amode_t am;
    } cgrf_state_t;

    cgrf_state_t state_reg;
    cgrf_state_t state_next;
    logic [31:0] alu_a;
    logic [31:0] alu_b;
    logic [31:0] alu_res;
    logic [3:0] alu_flags;
    cgrf_amode_t mode_now;
    // full-width views feeding the datapath and the address fetch
    logic [63:0] tgt_view;
    logic [63:0] src_view;
    logic [63:0] adr_wview;
    logic [63:0] adr_lview;
    cgrf_sel_t adr_wsel;
    cgrf_sel_t adr_lsel;

    // view read: byte, word, longword or quadword out of the longword store
    function automatic logic [63:0] cgrf_view(input logic [CGRF_NUM_LONGS-1:0][31:0] f,
                                              input cgrf_sel_t s);
        logic [31:0] w;
        logic [3:0] li;
        w = f[s.num[3:2]];
        li = s.num[4:1];
        cgrf_view = 64'h0;
        unique case (s.size)
            // byte n: word n/2, odd n low byte
            CGRF_SZ_BYTE: cgrf_view = {56'h0, (s.num[0] ? (s.num[1] ? w[7:0] : w[23:16])
                                            : (s.num[1] ? w[15:8] : w[31:24]))};
            // word n: even word upper half of its longword
            CGRF_SZ_WORD: cgrf_view = {48'h0, (s.num[0] ? f[s.num[4:1]][15:0]
                                            : f[s.num[4:1]][31:16])};
            CGRF_SZ_LONG: cgrf_view = {32'h0, f[li]};
            // quadword: even longword in upper half
            CGRF_SZ_QUAD: cgrf_view = {f[{li[3:1], 1'b0}], f[{li[3:1], 1'b1}]};
        endcase
    endfunction

    // view write: merge sized data into the store
    function automatic logic [CGRF_NUM_LONGS-1:0][31:0] cgrf_merge(
        input logic [CGRF_NUM_LONGS-1:0][31:0] f, input cgrf_sel_t s, input logic [63:0] d);
        logic [CGRF_NUM_LONGS-1:0][31:0] g;
        logic [3:0] wi;
        logic [3:0] li;
        g = f;
        wi = {2'b00, s.num[3:2]};
        li = s.num[4:1];
        unique case (s.size)
            CGRF_SZ_BYTE: begin
                unique case ({s.num[1], s.num[0]})
                    2'b00: g[wi][31:24] = d[7:0];
                    2'b01: g[wi][23:16] = d[7:0];
                    2'b10: g[wi][15:8] = d[7:0];
                    2'b11: g[wi][7:0] = d[7:0];
                endcase
            end
            CGRF_SZ_WORD: begin
                if (s.num[0]) begin
                    g[li][15:0] = d[15:0];
                end else begin
                    g[li][31:16] = d[15:0];
                end
            end
            CGRF_SZ_LONG: g[li] = d[31:0];
            CGRF_SZ_QUAD: begin
                g[{li[3:1], 1'b0}] = d[63:32];
                g[{li[3:1], 1'b1}] = d[31:0];
            end
        endcase
        return g;
    endfunction

    // address representation from the flag word
    assign mode_now = cgrf_amode_t'({state_reg.st.flag_control_word[CGRF_FCW_EC],
                                     state_reg.st.flag_control_word[CGRF_FCW_LS]});

    // operands for the sized datapath
    assign tgt_view = cgrf_view(state_reg.file, wr_sel);
    assign src_view = cgrf_view(state_reg.file, alu_src);
    assign alu_a = tgt_view[31:0];
    assign alu_b = src_view[31:0];

    // address register views: word in compact mode, longword otherwise
    assign adr_wsel = '{size: CGRF_SZ_WORD, num: addr_num};
    assign adr_lsel = '{size: CGRF_SZ_LONG, num: addr_num};
    assign adr_wview = cgrf_view(state_reg.file, adr_wsel);
    assign adr_lview = cgrf_view(state_reg.file, adr_lsel);

    cgrf_alu u_alu (
        .op(alu_op),
        .size(wr_sel.size),
        .a(alu_a),
        .b(alu_b),
        .res(alu_res),
        .flags(alu_flags)
    );

    // next state
    always_comb begin
        state_next = state_reg;
        state_next.rd_ok = 1'b0;
        state_next.ad_ok = 1'b0;
        state_next.ad_err = 1'b0;
        state_next.am = mode_now;
        if (rd_req) begin
            state_next.rd = cgrf_view(state_reg.file, rd_sel);
            state_next.rd_ok = 1'b1;
        end
        // plain write, or alu result written back with flags
        if (wr_req && alu_en) begin
            state_next.file = cgrf_merge(state_reg.file, wr_sel, {32'h0, alu_res});
            state_next.st.flag_control_word[CGRF_FCW_C] = alu_flags[3];
            state_next.st.flag_control_word[CGRF_FCW_Z] = alu_flags[2];
            state_next.st.flag_control_word[CGRF_FCW_S] = alu_flags[1];
            state_next.st.flag_control_word[CGRF_FCW_V] = alu_flags[0];
        end else if (wr_req) begin
            state_next.file = cgrf_merge(state_reg.file, wr_sel, wr_data);
        end
        // address fetch: word in compact, longword otherwise; number 0 refused
        if (addr_req) begin
            state_next.ad_ok = 1'b1;
            if (mode_now == CGRF_AM_COMPACT) begin
                state_next.ad = {16'h0, adr_wview[15:0]};
                state_next.ad_err = (addr_num == 5'h00);
            end else begin
                state_next.ad = adr_lview[31:0];
                state_next.ad_err = (addr_num == 5'h00) || addr_num[0] ||
                                    (mode_now == CGRF_AM_RESERVED);
            end
        end
        // stack and frame pointers per mode
        if (mode_now == CGRF_AM_COMPACT) begin
            state_next.sp = {16'h0, state_next.file[CGRF_WSP[4:1]][15:0]};
            state_next.fp = {16'h0, state_next.file[CGRF_WFP[4:1]][31:16]};
        end else begin
            state_next.sp = state_next.file[CGRF_LSP[4:1]];
            state_next.fp = state_next.file[CGRF_LFP[4:1]];
        end
        if (pc_load) begin
            state_next.st.pc = pc_value;
        end
        if (fcw_load) begin
            state_next.st.flag_control_word = fcw_value;
        end
        // trap saves the program status before the new status is loaded
        if (trap_take) begin
            state_next.sv = state_reg.st;
            state_next.sv_ok = 1'b1;
            state_next.st.pc = trap_pc;
            state_next.st.flag_control_word = trap_fcw;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.st <= '{pc: CGRF_PC_RST, flag_control_word: CGRF_FCW_RST};
            state_reg.sv <= '{pc: CGRF_PC_RST, flag_control_word: CGRF_FCW_RST};
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign rd_data = state_reg.rd;
    assign rd_valid = state_reg.rd_ok;
    assign addr_data = state_reg.ad;
    assign addr_valid = state_reg.ad_ok;
    assign addr_err = state_reg.ad_err;
    assign stack_ptr = state_reg.sp;
    assign frame_ptr = state_reg.fp;
    assign addr_mode = state_reg.am;
    assign status = state_reg.st;
    assign saved_status = state_reg.sv;
    assign saved_valid = state_reg.sv_ok;
endmodule

/* File: inc/cgrf_pkg.sv */
// Purpose: shared constants and carriers for the general register file
// Assumes: one core clock, synchronous active-low reset
// Notes: byte/word/longword/quadword views all alias one 64-byte store
package cgrf_pkg;
    localparam int CGRF_NUM_LONGS = 16;
    localparam int CGRF_BYTES = 64;
    localparam int CGRF_BYTE_REGS = 16;
    localparam int CGRF_WORD_REGS = 16;
    // register numbers
    localparam logic [4:0] CGRF_WSP = 5'h0F;
    localparam logic [4:0] CGRF_WFP = 5'h0E;
    localparam logic [4:0] CGRF_LSP = 5'h0E;
    localparam logic [4:0] CGRF_LFP = 5'h0C;
    // flag and control word fields
    localparam int CGRF_FCW_EC = 15;
    localparam int CGRF_FCW_LS = 14;
    localparam int CGRF_FCW_SN = 13;
    localparam int CGRF_FCW_C = 7;
    localparam int CGRF_FCW_Z = 6;
    localparam int CGRF_FCW_S = 5;
    localparam int CGRF_FCW_V = 4;
    localparam logic [15:0] CGRF_FCW_RST = 16'h0000;
    localparam logic [31:0] CGRF_PC_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        CGRF_SZ_BYTE = 2'b00,
        CGRF_SZ_WORD = 2'b01,
        CGRF_SZ_LONG = 2'b10,
        CGRF_SZ_QUAD = 2'b11
    } cgrf_size_t;

    typedef enum logic [1:0] {
        CGRF_AM_COMPACT = 2'b00,
        CGRF_AM_RESERVED = 2'b01,
        CGRF_AM_SEGMENTED = 2'b10,
        CGRF_AM_LINEAR = 2'b11
    } cgrf_amode_t;

    typedef enum logic [2:0] {
        CGRF_OP_PASS = 3'b000,
        CGRF_OP_ADD = 3'b001,
        CGRF_OP_SUB = 3'b010,
        CGRF_OP_AND = 3'b011,
        CGRF_OP_OR = 3'b100,
        CGRF_OP_XOR = 3'b101
    } cgrf_op_t;

    // one register access: size and register number
    typedef struct packed {
        cgrf_size_t size;
        logic [4:0] num;
    } cgrf_sel_t;

    typedef struct packed {
        logic [31:0] pc;
        logic [15:0] flag_control_word;
    } cgrf_status_t;
endpackage

/* File: design/cgrf_alu.sv */
// Purpose: sized logical and arithmetic unit fed by the register file
// Assumes: operands right-aligned in 32 bits
// Notes: flags reflect the selected operand width only
`timescale 1ns/1ps
module cgrf_alu
    import cgrf_pkg::*;
(
    // operation
    input wire cgrf_op_t op,
    input wire cgrf_size_t size,
    // operands
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    // result
    output logic [31:0] res,
    output logic [3:0] flags
);
    logic [32:0] sum;
    logic [31:0] raw;
    logic [31:0] mask;
    logic msb;
    logic carry;
    logic ovf;
    logic asgn;
    logic bsgn;

    // width-masked operation and flag generation
    always_comb begin
        sum = 33'h0_0000_0000;
        unique case (size)
            CGRF_SZ_BYTE: mask = 32'h0000_00FF;
            CGRF_SZ_WORD: mask = 32'h0000_FFFF;
            default: mask = 32'hFFFF_FFFF;
        endcase
        unique case (op)
            CGRF_OP_ADD: sum = {1'b0, a & mask} + {1'b0, b & mask};
            CGRF_OP_SUB: sum = {1'b0, a & mask} - {1'b0, b & mask};
            default: sum = 33'h0_0000_0000;
        endcase
        unique case (op)
            CGRF_OP_ADD, CGRF_OP_SUB: raw = sum[31:0];
            CGRF_OP_AND: raw = a & b;
            CGRF_OP_OR: raw = a | b;
            CGRF_OP_XOR: raw = a ^ b;
            default: raw = b;
        endcase
        res = raw & mask;
        unique case (size)
            CGRF_SZ_BYTE: begin
                msb = res[7];
                carry = sum[8];
                asgn = a[7];
                bsgn = b[7];
            end
            CGRF_SZ_WORD: begin
                msb = res[15];
                carry = sum[16];
                asgn = a[15];
                bsgn = b[15];
            end
            default: begin
                msb = res[31];
                carry = sum[32];
                asgn = a[31];
                bsgn = b[31];
            end
        endcase
        if (op == CGRF_OP_ADD) begin
            ovf = (asgn == bsgn) && (msb != asgn);
        end else if (op == CGRF_OP_SUB) begin
            ovf = (asgn != bsgn) && (msb != asgn);
        end else begin
            ovf = 1'b0;
        end
        // c z s v
        flags = {carry, (res == 32'h0000_0000), msb, ovf};
    end
endmodule

/* File: tb/cgrf_regfile_props.sv */
// Purpose: port-level properties of the general register file
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/1ps
module cgrf_regfile_props
    import cgrf_pkg::*;
(
    // clock and control
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // requests
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic alu_en,
    input wire logic addr_req,
    input wire logic [4:0] addr_num,
    input wire logic pc_load,
    input wire logic [31:0] pc_value,
    input wire logic fcw_load,
    input wire logic [15:0] fcw_value,
    input wire logic trap_take,
    input wire logic [31:0] trap_pc,
    input wire logic [15:0] trap_fcw,
    // answers
    input wire logic rd_valid,
    input wire logic addr_valid,
    input wire logic addr_err,
    input wire cgrf_amode_t addr_mode,
    input wire cgrf_status_t status,
    input wire cgrf_status_t saved_status,
    input wire logic saved_valid
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // request acceptance steps
    sequence s_read_taken;
        rd_req && clk_en;
    endsequence
    sequence s_addr_taken;
        addr_req && clk_en;
    endsequence
    sequence s_trap;
        trap_take && clk_en;
    endsequence

    a_read_valid_pulse: assert property (s_read_taken |=> rd_valid)
        else $error("read not answered next cycle");
    a_valid_needs_req: assert property (clk_en |=> rd_valid == $past(rd_req))
        else $error("read valid without a request");
    a_addr_answered: assert property (s_addr_taken |=> addr_valid || addr_err)
        else $error("address fetch not answered");
    a_addr_zero_err: assert property (s_addr_taken ##0 (addr_num == 5'h00) |=> addr_err)
        else $error("register zero accepted as address");
    a_mode_follows_fcw: assert property (clk_en |=>
        addr_mode == $past({status.flag_control_word[CGRF_FCW_EC], status.flag_control_word[CGRF_FCW_LS]}))
        else $error("address mode does not follow flag word");
    a_trap_saves_status: assert property (s_trap |=> saved_valid
        && saved_status == $past(status)
        && status == {$past(trap_pc), $past(trap_fcw)})
        else $error("trap did not save status");
    a_saved_sticky: assert property (saved_valid |=> saved_valid)
        else $error("saved flag dropped");
    a_pc_load: assert property (pc_load && !trap_take && clk_en |=>
        status.pc == $past(pc_value))
        else $error("program counter not loaded");
    a_fcw_load: assert property (fcw_load && !trap_take && clk_en |=>
        status.flag_control_word == $past(fcw_value))
        else $error("flag word not loaded");
endmodule

/* File: tb/cgrf_regfile_test.sv */
// Purpose: self-checking bench of the general register file
// Assumes: 250 MHz sys_clk, reset held 10 cycles
// Notes: each scenario drives the ports and judges the answers itself
`timescale 1ns/1ps
module cgrf_regfile_test;
    import cgrf_pkg::*;
    logic sys_clk, reset_n, clk_en, rd_req, wr_req, alu_en, addr_req;
    logic pc_load, fcw_load, trap_take, rd_valid, addr_valid, addr_err, saved_valid;
    cgrf_sel_t rd_sel, wr_sel, alu_src;
    cgrf_op_t alu_op;
    cgrf_amode_t addr_mode;
    cgrf_status_t status, saved_status;
    logic [63:0] wr_data, rd_data;
    logic [31:0] pc_value, trap_pc, addr_data, stack_ptr, frame_ptr;
    logic [15:0] fcw_value, trap_fcw;
    logic [4:0] addr_num;
    int errors = 0;
    int checks = 0;

    cgrf_regfile uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .rd_req(rd_req), .rd_sel(rd_sel), .wr_req(wr_req), .wr_sel(wr_sel),
        .wr_data(wr_data), .alu_en(alu_en), .alu_op(alu_op), .alu_src(alu_src),
        .addr_req(addr_req), .addr_num(addr_num), .pc_load(pc_load),
        .pc_value(pc_value), .fcw_load(fcw_load), .fcw_value(fcw_value),
        .trap_take(trap_take), .trap_pc(trap_pc), .trap_fcw(trap_fcw),
        .rd_data(rd_data), .rd_valid(rd_valid), .addr_data(addr_data),
        .addr_valid(addr_valid), .addr_err(addr_err), .stack_ptr(stack_ptr),
        .frame_ptr(frame_ptr), .addr_mode(addr_mode), .status(status),
        .saved_status(saved_status), .saved_valid(saved_valid));

    // clock
    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;

    // compare and count
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write, plain or through the alu
    task automatic put(input logic use_alu, input cgrf_op_t op, input cgrf_sel_t sel,
        input logic [63:0] d, input cgrf_sel_t src);
        @(posedge sys_clk);
        wr_req <= 1'b1;
        alu_en <= use_alu;
        alu_op <= op;
        wr_sel <= sel;
        wr_data <= d;
        alu_src <= src;
        @(posedge sys_clk);
        wr_req <= 1'b0;
        alu_en <= 1'b0;
    endtask

    task automatic rd(input cgrf_sel_t sel, input logic [63:0] exp);
        @(posedge sys_clk);
        rd_req <= 1'b1;
        rd_sel <= sel;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        #1;
        chk("rd_valid", 64'h1, {63'h0, rd_valid});
        chk("rd_data", exp, rd_data);
    endtask

    task automatic fetch(input logic [4:0] n, input logic err, input logic [31:0] exp);
        @(posedge sys_clk);
        addr_req <= 1'b1;
        addr_num <= n;
        @(posedge sys_clk);
        addr_req <= 1'b0;
        #1;
        chk("addr_err", {63'h0, err}, {63'h0, addr_err});
        if (!err) chk("addr_data", {32'h0, exp}, {32'h0, addr_data});
    endtask

    // aliasing of byte, word and longword views
    task automatic t_alias();
        put(1'b0, CGRF_OP_PASS, {CGRF_SZ_LONG, 5'h04}, 64'h1234_5678, '0);
        rd({CGRF_SZ_LONG, 5'h04}, 64'h1234_5678);
        rd({CGRF_SZ_WORD, 5'h04}, 64'h1234);
        rd({CGRF_SZ_WORD, 5'h05}, 64'h5678);
        rd({CGRF_SZ_BYTE, 5'h08}, 64'h12);
        rd({CGRF_SZ_BYTE, 5'h0B}, 64'h78);
    endtask

    // quadword spans two longwords
    task automatic t_quad();
        put(1'b0, CGRF_OP_PASS, {CGRF_SZ_QUAD, 5'h04}, 64'h0123_4567_89AB_CDEF, '0);
        rd({CGRF_SZ_LONG, 5'h04}, 64'h0123_4567);
        rd({CGRF_SZ_LONG, 5'h06}, 64'h89AB_CDEF);
        rd({CGRF_SZ_QUAD, 5'h04}, 64'h0123_4567_89AB_CDEF);
    endtask

    // sized arithmetic and flags
    task automatic t_alu();
        put(1'b0, CGRF_OP_PASS, {CGRF_SZ_WORD, 5'h02}, 64'hFFFF, '0);
        put(1'b0, CGRF_OP_PASS, {CGRF_SZ_WORD, 5'h03}, 64'h0001, '0);
        put(1'b1, CGRF_OP_ADD, {CGRF_SZ_WORD, 5'h02}, '0, {CGRF_SZ_WORD, 5'h03});
        rd({CGRF_SZ_WORD, 5'h02}, 64'h0);
        chk("zero_carry", 64'h3, {62'h0, status.flag_control_word[CGRF_FCW_C], status.flag_control_word[CGRF_FCW_Z]});
        put(1'b1, CGRF_OP_SUB, {CGRF_SZ_WORD, 5'h02}, '0, {CGRF_SZ_WORD, 5'h03});
        rd({CGRF_SZ_WORD, 5'h02}, 64'hFFFF);
        chk("sign_zero", 64'h2, {62'h0, status.flag_control_word[CGRF_FCW_S], status.flag_control_word[CGRF_FCW_Z]});
        put(1'b1, CGRF_OP_XOR, {CGRF_SZ_BYTE, 5'h04}, '0, {CGRF_SZ_BYTE, 5'h07});
        rd({CGRF_SZ_WORD, 5'h02}, 64'hFEFF);
    endtask

    // mode and address fetch in every representation, pointers in all but reserved
    task automatic t_modes();
        logic [15:0] flag_control_word [4] = '{16'h0000, 16'h8000, 16'hC000, 16'h4000};
        logic [1:0] mode [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
        put(1'b0, CGRF_OP_PASS, {CGRF_SZ_LONG, 5'h0E}, 64'hABCD_1234, '0);
        put(1'b0, CGRF_OP_PASS, {CGRF_SZ_LONG, 5'h0C}, 64'h5566_7788, '0);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            fcw_load <= 1'b1;
            fcw_value <= flag_control_word[i];
            @(posedge sys_clk);
            fcw_load <= 1'b0;
            repeat (2) @(posedge sys_clk);
            #1;
            chk("addr_mode", {62'h0, mode[i]}, {62'h0, addr_mode});
            if (i == 0) begin
                chk("stack_ptr", 64'h1234, {32'h0, stack_ptr});
                chk("frame_ptr", 64'hABCD, {32'h0, frame_ptr});
                fetch(5'h0E, 1'b0, 32'hABCD);
            end else if (i < 3) begin
                chk("stack_ptr", 64'hABCD_1234, {32'h0, stack_ptr});
                chk("frame_ptr", 64'h5566_7788, {32'h0, frame_ptr});
                fetch(5'h0E, 1'b0, 32'hABCD_1234);
                fetch(5'h0D, 1'b1, '0);
            end else begin
                fetch(5'h0E, 1'b1, '0);
            end
            fetch(5'h00, 1'b1, '0);
        end
    endtask

    // a write held while the clock enable is low must not land
    task automatic t_freeze();
        put(1'b0, CGRF_OP_PASS, {CGRF_SZ_LONG, 5'h10}, 64'hCAFE_0001, '0);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr_req <= 1'b1;
        wr_sel <= {CGRF_SZ_LONG, 5'h10};
        wr_data <= 64'h0BAD_0002;
        repeat (3) @(posedge sys_clk);
        wr_req <= 1'b0;
        clk_en <= 1'b1;
        rd({CGRF_SZ_LONG, 5'h10}, 64'hCAFE_0001);
    endtask

    // program status saved on a trap
    task automatic t_trap();
        @(posedge sys_clk);
        pc_load <= 1'b1;
        pc_value <= 32'h0000_1000;
        fcw_load <= 1'b1;
        fcw_value <= 16'h8000;
        @(posedge sys_clk);
        pc_load <= 1'b0;
        fcw_load <= 1'b0;
        trap_take <= 1'b1;
        trap_pc <= 32'h0000_2000;
        trap_fcw <= 16'hC000;
        @(posedge sys_clk);
        trap_take <= 1'b0;
        #1;
        chk("saved_status", 64'h1000_8000, {16'h0, saved_status});
        chk("status", 64'h2000_C000, {16'h0, status});
        chk("saved_valid", 64'h1, {63'h0, saved_valid});
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence
    initial begin
        {reset_n, rd_req, wr_req, alu_en, addr_req, pc_load, fcw_load, trap_take} = '0;
        clk_en = 1'b1;
        {rd_sel, wr_sel, alu_src, alu_op, wr_data, addr_num} = '0;
        {pc_value, trap_pc, fcw_value, trap_fcw} = '0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_alias();
        t_quad();
        t_alu();
        t_modes();
        t_freeze();
        t_trap();
        conclude();
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        conclude();
    end
endmodule

bind cgrf_regfile cgrf_regfile_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .rd_req(rd_req), .wr_req(wr_req), .alu_en(alu_en),
    .addr_req(addr_req), .addr_num(addr_num), .pc_load(pc_load), .pc_value(pc_value),
    .fcw_load(fcw_load), .fcw_value(fcw_value), .trap_take(trap_take),
    .trap_pc(trap_pc), .trap_fcw(trap_fcw), .rd_valid(rd_valid),
    .addr_valid(addr_valid), .addr_err(addr_err), .addr_mode(addr_mode),
    .status(status), .saved_status(saved_status), .saved_valid(saved_valid));
